// file: src/sram_host.v
// Purpose: Clocked host that reads and writes an async 16K x 1 memory
// Assumes: One request at a time; memory pins driven straight from flops
// Notes:   Write is strobe controlled with select fall first; reads
//          sample after the access time rounded up to clocks
//          Timing counts are cut to the four-bit timer width
`timescale 1ns/100ps
`default_nettype none
`include "sram_host_defs.vh"

module sram_host #(
	parameter ADDR_WIDTH   = `ADDR_WIDTH,
	parameter ACCESS_NS    = `ACCESS_NS,
	parameter WCYCLE_NS    = `WRITE_CYCLE_NS,
	parameter WPULSE_NS    = `WRITE_PULSE_NS,
	parameter SEL_END_NS   = `SELECT_TO_END_NS,
	parameter ADDR_END_NS  = `ADDR_SETUP_END_NS,
	parameter DSETUP_NS    = `DATA_SETUP_NS,
	parameter FLOAT_NS     = `OUTPUT_FLOAT_NS
) (
	input  wire                  ref_clk,
	input  wire                  sys_rst,
	input  wire                  req_valid,
	input  wire                  req_write,
	input  wire [ADDR_WIDTH-1:0] req_addr,
	input  wire                  req_data,
	output reg                   req_ready,
	output reg                   rsp_valid,
	output reg                   rsp_data,
	output reg                   select_n,
	output reg                   write_n,
	output reg  [ADDR_WIDTH-1:0] cell_address,
	output reg                   data_in,
	input  wire                  data_out
);

	// ----------------------------------------------------------------
	// Derived clock counts
	// ----------------------------------------------------------------
	// Whole-clock counts, rounded up, never below one
	localparam integer RD_INT   = `NS_TO_CLK(ACCESS_NS);
	localparam integer WPUL_INT = `NS_TO_CLK(WPULSE_NS);
	localparam integer SEL_INT  = `NS_TO_CLK(SEL_END_NS);
	localparam integer ADR_INT  = `NS_TO_CLK(ADDR_END_NS);
	localparam integer DSU_INT  = `NS_TO_CLK(DSETUP_NS);
	localparam integer WCYC_INT = `NS_TO_CLK(WCYCLE_NS);
	localparam integer FLT_INT  = `NS_TO_CLK(FLOAT_NS);

	// Cut to the timer width on purpose
	localparam [3:0] RD_CLK   = RD_INT[3:0];
	localparam [3:0] PULSE_A  = WPUL_INT[3:0];
	localparam [3:0] PULSE_B  = SEL_INT[3:0];
	localparam [3:0] PULSE_C  = ADR_INT[3:0];
	localparam [3:0] PULSE_D  = DSU_INT[3:0];
	localparam [3:0] WCYC_CLK = WCYC_INT[3:0];
	localparam [3:0] FLT_CLK  = FLT_INT[3:0];

	function [3:0] max2;
		input [3:0] a;
		input [3:0] b;
		begin
			max2 = (a > b) ? a : b;
		end
	endfunction

	// Difference that stops at zero instead of wrapping
	function [3:0] sub_sat;
		input [3:0] a;
		input [3:0] b;
		begin
			sub_sat = (a > b) ? (a - b) : 4'h0;
		end
	endfunction

	// Strobe low long enough for pulse, select, address and data setup
	localparam [3:0] WP_CLK = max2(max2(PULSE_A, PULSE_B),
		max2(PULSE_C, PULSE_D));

	// Gap after select rises: rest of the write cycle, at least float time
	localparam [3:0] WGAP_CLK = max2(sub_sat(WCYC_CLK, WP_CLK + 4'h1),
		FLT_CLK) - 4'h1;

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_RACC  = 3'h1;
	localparam [2:0] S_WSET  = 3'h2;
	localparam [2:0] S_WPUL  = 3'h3;
	localparam [2:0] S_WEND  = 3'h4;
	localparam [2:0] S_GAP   = 3'h5;

	reg  [2:0] state;
	reg  [2:0] next_state;
	reg        t_load;
	reg  [3:0] t_value;
	wire       t_done;

	// One shared wait timer for every timed phase
	cycle_timer #(
		.WIDTH (4)
	) u_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.load    (t_load),
		.value   (t_value),
		.done    (t_done)
	);

	// ----------------------------------------------------------------
	// Next state and timer loads
	// ----------------------------------------------------------------
	always @* begin
		next_state = state;
		t_load     = 1'b0;
		t_value    = 4'h0;
		case (state)
		S_IDLE: begin
			if (req_valid && req_ready) begin
				t_load = 1'b1;
				if (req_write) begin
					next_state = S_WSET;
					t_value    = 4'h0;
				end else begin
					next_state = S_RACC;
					t_value    = RD_CLK - 4'h1;
				end
			end
		end
		S_RACC: begin
			// Wait out the access time
			if (t_done)
				next_state = S_GAP;
		end
		S_WSET: begin
			// Strobe falls one clock after select and address
			next_state = S_WPUL;
			t_load     = 1'b1;
			t_value    = WP_CLK - 4'h1;
		end
		S_WPUL: begin
			if (t_done)
				next_state = S_WEND;
		end
		S_WEND: begin
			next_state = S_GAP;
			t_load     = 1'b1;
			t_value    = WGAP_CLK;
		end
		S_GAP: begin
			// After a read the timer is already zero
			if (t_done)
				next_state = S_IDLE;
		end
		default: next_state = S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Pin and response registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state        <= S_IDLE;
			select_n     <= 1'b1;
			write_n      <= 1'b1;
			cell_address <= {ADDR_WIDTH{1'b0}};
			data_in      <= 1'b0;
			req_ready    <= 1'b0;
			rsp_valid    <= 1'b0;
			rsp_data     <= 1'b0;
		end else begin
			state     <= next_state;
			rsp_valid <= 1'b0;
			case (state)
			S_IDLE: begin
				// Take one request; address and data go out with select
				req_ready <= 1'b1;
				if (req_valid && req_ready) begin
					req_ready    <= 1'b0;
					// Address set while strobe is high; select falls on the same edge
					cell_address <= req_addr;
					data_in      <= req_data;
					select_n     <= 1'b0;
				end
			end
			S_RACC: begin
				// Sample the bit, then deselect before any address change
				if (t_done) begin
					rsp_valid <= 1'b1;
					rsp_data  <= data_out;
					select_n  <= 1'b1;
				end
			end
			S_WSET: begin
				// Address and data have stood one clock already
				write_n <= 1'b0;
			end
			S_WPUL: begin
				// Strobe rise ends the write with select still low
				if (t_done)
					write_n <= 1'b1;
			end
			S_WEND: begin
				// Address and data hold past the strobe rise
				select_n  <= 1'b1;
				rsp_valid <= 1'b1;
				rsp_data  <= data_in;
			end
			S_GAP: begin
				// Ready again once the gap has run out
				if (t_done)
					req_ready <= 1'b1;
			end
			default: begin
				select_n <= 1'b1;
				write_n  <= 1'b1;
			end
			endcase
		end
	end

endmodule // sram_host

`default_nettype wire

// file: src/sram_host_defs.vh
// Purpose: Timing constants for the asynchronous 16K x 1 memory host
// Assumes: ref_clk at 125 MHz (8 ns period)
// Notes:   Notes on behaviour list below
//
// Notes on behaviour
// - Strobe high with select low is a read; memory drives the bit.
// - With select low, address may change every address access time.
// - Host keeps select or strobe high while the address changes.
// - Host makes each write cycle last at least the grade cycle time.
// - Host holds write strobe low at least the grade pulse width.
// - Host holds select low a minimum time before write end.
// - Address valid from write start, held to end, set up before end.
// - Input bit set up before the rising edge ending the write.
// - Write begins at the later falling of select or strobe.
`ifndef SRAM_HOST_DEFS_VH
`define SRAM_HOST_DEFS_VH

// ----------------------------------------------------------------
// Clock and geometry
// ----------------------------------------------------------------
`define CLK_PERIOD_NS       8
`define ADDR_WIDTH          14

// ----------------------------------------------------------------
// Fastest-grade times in ns (defaults)
// ----------------------------------------------------------------
`define ACCESS_NS           25
`define WRITE_CYCLE_NS      20
`define WRITE_PULSE_NS      15
`define SELECT_TO_END_NS    20
`define ADDR_SETUP_END_NS   20
`define DATA_SETUP_NS       15
`define OUTPUT_FLOAT_NS     20

// Round up to whole clocks, never below one
`define NS_TO_CLK(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
	(((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`endif

// file: src/cycle_timer.v
// Purpose: Down counter that reports when a loaded wait has run out
// Assumes: load has priority over counting
// Notes:   done is high while the count is zero
`timescale 1ns/100ps
`default_nettype none

module cycle_timer #(
	parameter WIDTH = 4
) (
	input  wire             ref_clk,
	input  wire             sys_rst,
	input  wire             load,
	input  wire [WIDTH-1:0] value,
	output wire             done
);

	reg [WIDTH-1:0] count;

	always @(posedge ref_clk) begin
		if (sys_rst)
			count <= {WIDTH{1'b0}};
		else if (load)
			count <= value;
		else if (count != {WIDTH{1'b0}})
			count <= count - 1'b1;
	end

	assign done = (count == {WIDTH{1'b0}});

endmodule // cycle_timer

`default_nettype wire

// file: test/sram_host_chk.sv
// Purpose: Port checks for sram_host
// Assumes: Default timing parameters
// Notes:   Bound to every sram_host
`timescale 1ns/100ps
`default_nettype none
module sram_host_chk (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        req_valid,
	input wire logic        req_write,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic        select_n,
	input wire logic        write_n,
	input wire logic [13:0] cell_address,
	input wire logic        data_in
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire take = req_valid && req_ready;
	rd_seq_a: assert property (take && !req_write
		|=> (!select_n && write_n)[*4] ##1 select_n) else $error("read");
	rd_rsp_a: assert property (take && !req_write
		|-> ##5 rsp_valid) else $error("read answer");
	wr_seq_a: assert property (take && req_write
		|=> !select_n && write_n ##1 !write_n[*3] ##1 write_n && !select_n
		##1 select_n && rsp_valid) else $error("write");
	addr_hold_a: assert property (!$stable(cell_address)
		|-> select_n || write_n) else $error("address moved");
	data_hold_a: assert property (!write_n
		|-> $stable(data_in)) else $error("data moved");
	pulse_min_a: assert property ($fell(write_n)
		|-> !write_n[*3]) else $error("short pulse");
	sel_first_a: assert property (!write_n
		|-> !select_n && !$past(select_n)) else $error("select late");
	end_sel_a: assert property ($rose(write_n)
		|-> !select_n) else $error("strobe end");
	idle_a: assert property (select_n |-> write_n) else $error("idle");
	busy_a: assert property (take |=> !req_ready) else $error("busy");
	c_rd: cover property (take && !req_write);
	c_wr: cover property (take && req_write);
	c_b2b: cover property (rsp_valid ##[1:4] take);
endmodule // sram_host_chk
bind sram_host sram_host_chk chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.req_valid(req_valid), .req_write(req_write), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .select_n(select_n), .write_n(write_n),
	.cell_address(cell_address), .data_in(data_in));
`default_nettype wire

// file: test/sram_cell_model.sv
// Purpose: Behavioural 16K x 1 memory
// Assumes: Output valid ACC ns after select
// Notes:   A floating output toggles
`timescale 1ns/100ps
`default_nettype none
module sram_cell_model #(
	parameter int ACC = 25
) (
	input  wire logic        select_n,
	input  wire logic        write_n,
	input  wire logic [13:0] cell_address,
	input  wire logic        data_in,
	output wire logic        data_out
);
	logic mem [0:16383];
	logic junk = 1'b0;
	logic wr_first = 1'b0;
	wire  drive = !select_n && write_n && !wr_first;
	wire  ok;
	always #3 junk = ~junk;
	always @(negedge select_n) wr_first = !write_n;
	always @(posedge write_n or posedge select_n)
		if (!select_n || !write_n) mem[cell_address] = data_in;
	assign #(ACC) ok = drive;
	assign data_out = ok && drive ? mem[cell_address] : junk;
endmodule // sram_cell_model
`default_nettype wire

// file: test/async_sram_16k_x1_access_bench.sv
// Purpose: Self-checking bench for sram_host
// Assumes: Default timing, 125 MHz clock
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/100ps
`default_nettype none
`include "sram_host_defs.vh"
module async_sram_16k_x1_access_bench;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [13:0] req_addr = 14'h0;
	logic        req_data = 1'b0;
	wire         req_ready, rsp_valid, rsp_data, select_n, write_n;
	wire         data_in, data_out;
	wire  [13:0] cell_address;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	function automatic int mx(int a, int b);
		return (a > b) ? a : b;
	endfunction
	localparam int RD_LAT = `NS_TO_CLK(`ACCESS_NS);
	localparam int WR_LAT = 2 + mx(mx(`NS_TO_CLK(`WRITE_PULSE_NS),
		`NS_TO_CLK(`SELECT_TO_END_NS)), mx(`NS_TO_CLK(`ADDR_SETUP_END_NS),
		`NS_TO_CLK(`DATA_SETUP_NS)));
	always #4 ref_clk = ~ref_clk;
	sram_host dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .select_n(select_n), .write_n(write_n),
		.cell_address(cell_address), .data_in(data_in), .data_out(data_out));
	sram_cell_model mem_u (.select_n(select_n), .write_n(write_n),
		.cell_address(cell_address), .data_in(data_in), .data_out(data_out));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop;
		end
	end
	task automatic chk(input string nm, input logic [13:0] e, g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic take(input logic w, input logic [13:0] a, input logic d);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_data = d;
		while (req_ready !== 1'b1) @(posedge ref_clk) #1;
		@(posedge ref_clk) #1;
		req_valid = 1'b0;
	endtask
	task automatic op(input logic w, input logic [13:0] a, input logic d, e);
		int n;
		n = 0;
		take(w, a, d);
		while (rsp_valid !== 1'b1 && n < 20) begin
			@(posedge ref_clk) #1;
			n++;
		end
		chk("latency", w ? 14'(WR_LAT) : 14'(RD_LAT), 14'(n));
		chk("rsp_data", {13'h0, e}, {13'h0, rsp_data});
	endtask
	task automatic t_reset;
		chk("select_n", 14'h1, {13'h0, select_n});
		chk("write_n", 14'h1, {13'h0, write_n});
		chk("req_ready", 14'h0, {13'h0, req_ready});
	endtask
	task automatic t_cells;
		op(1'b1, 14'h0000, 1'b1, 1'b1);
		op(1'b1, 14'h3fff, 1'b0, 1'b0);
		op(1'b1, 14'h1555, 1'b1, 1'b1);
		op(1'b0, 14'h3fff, 1'b1, 1'b0);
		op(1'b0, 14'h0000, 1'b0, 1'b1);
		op(1'b1, 14'h0000, 1'b0, 1'b0);
		op(1'b0, 14'h0000, 1'b1, 1'b0);
	endtask
	task automatic t_midreset;
		take(1'b1, 14'h2aaa, 1'b1);
		repeat (2) @(posedge ref_clk) #1;
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk) #1;
		sys_rst = 1'b0;
		t_reset;
		op(1'b0, 14'h1555, 1'b0, 1'b1);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk) #1;
		t_reset;
		sys_rst = 1'b0;
		t_cells;
		t_midreset;
		report_and_stop;
	end
endmodule // async_sram_16k_x1_access_bench
`default_nettype wire
